/* periph_clock_model.sv */
`timescale 1ns/100ps
// Oscillator side: one enable pulse per bus_clk_quad period, free running
module periph_clock_model #(
    parameter int DIV = 2
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      quad_tick_o
);
    int cnt;
    // Keeps ticking through stop, or the recovery count could never finish
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            quad_tick_o <= 1'b0;
        end else begin
            cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
            quad_tick_o <= (cnt == DIV - 1);
        end
    end
endmodule

/* sim_ctrl_pkg.sv */
package sim_ctrl_pkg;
    // Register byte addresses
    localparam logic [11:0] PENDING_IRQ_STATUS_HI_ADDR = 12'h000;
    localparam logic [11:0] RESET_CAUSE_STATUS_ADDR    = 12'h004;
    localparam logic [11:0] BREAK_FLAG_CONTROL_ADDR    = 12'h008;
    localparam logic [11:0] LOWPOWER_STATUS_ADDR       = 12'h00C;
    localparam logic [11:0] LOWPOWER_CONFIG_ADDR       = 12'h010;
    // Reset cause field positions
    localparam int POWER_UP_BIT     = 7;
    localparam int EXT_PIN_BIT      = 6;
    localparam int WATCHDOG_BIT     = 5;
    localparam int BAD_OPCODE_BIT   = 4;
    localparam int BAD_FETCH_BIT    = 3;
    localparam int MONITOR_BIT      = 2;
    localparam int BROWNOUT_BIT     = 1;
    // Break flag control field
    localparam int BREAK_CLEAR_ENABLE_BIT = 7;
    // Low-power status fields
    localparam int WAIT_ACTIVE_BIT  = 0;
    localparam int STOP_ACTIVE_BIT  = 1;
    localparam int RECOVERING_BIT   = 2;
    localparam int BREAK_WAIT_BIT   = 3;
    // Low-power config fields
    localparam int SHORT_RECOVERY_BIT = 0;
    localparam int OSC_IN_STOP_BIT    = 1;
    localparam int WATCHDOG_DIS_BIT   = 2;
    // Reset values
    localparam logic [7:0] PENDING_RESET = 8'h00;
    localparam logic [7:0] CAUSE_RESET   = 8'h80;
    localparam logic [7:0] BFC_RESET     = 8'h00;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    // Stop recovery in bus_clk_quad cycles
    localparam int LONG_RECOVERY_CYCLES  = 4096;
    localparam int SHORT_RECOVERY_CYCLES = 32;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        RUN,
        WAITING,
        STOPPED,
        RECOVER,
        STACKING
    } power_state_t;
endpackage

/* sim_reset_lowpower_ctrl.sv */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module sim_reset_lowpower_ctrl
    import sim_ctrl_pkg::*;
#(
    parameter int LONG_RECOVERY  = LONG_RECOVERY_CYCLES,
    parameter int SHORT_RECOVERY = SHORT_RECOVERY_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Interrupt request sources, bit 0 is conversion done
    input  wire logic [7:0]  pending_source_flags_i,
    input  wire logic        irq_enabled_i,
    // Reset causes, pulses from the reset logic
    input  wire logic        power_up_i,
    input  wire logic        ext_pin_rst_i,
    input  wire logic        watchdog_rst_i,
    input  wire logic        bad_opcode_rst_i,
    input  wire logic        bad_fetch_rst_i,
    input  wire logic        monitor_entry_rst_i,
    input  wire logic        brownout_rst_i,
    // Core and break
    input  wire logic        break_req_i,
    input  wire logic        break_state_i,
    input  wire logic        wait_instr_i,
    input  wire logic        stop_instr_i,
    input  wire logic        quad_tick_i,
    input  wire logic        flag_clear_req_i,
    output logic             force_trap_vector_o,
    output logic             clear_irq_mask_o,
    output logic             core_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             clk_double_en_o,
    output logic             clk_quad_en_o,
    output logic             watchdog_run_o,
    output logic             stack_start_o,
    output logic             flag_clear_allow_o,
    output logic             sys_reset_o
);

    localparam logic [12:0] LONG_CNT  = 13'(LONG_RECOVERY);
    localparam logic [12:0] SHORT_CNT = 13'(SHORT_RECOVERY);

    initial begin
        if (LONG_RECOVERY < 1 || LONG_RECOVERY > 8191 || SHORT_RECOVERY < 1
            || SHORT_RECOVERY > LONG_RECOVERY) begin
            $error("Recovery counts out of range");
        end
    end

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] target);
        addr_hit = (a == target);
    endfunction

    typedef struct packed {
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic [7:0]   pending;
        logic [7:0]   cause;
        logic [7:0]   bfc;
        logic [7:0]   config_bits;
        logic         break_wait;
        power_state_t pstate;
        logic [12:0]  counter;
        logic         trap;
        logic         clr_mask;
        logic         core_en;
        logic         periph_en;
        logic         dbl_en;
        logic         quad_en;
        logic         wdog_run;
        logic         stack;
        logic         clr_allow;
        logic         sysrst;
        logic         cause_clear;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic   any_reset;
    logic   access;
    logic   commit;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_cur = cur;
        // All sources feed one OR; none outranks another
        any_reset = power_up_i | ext_pin_rst_i | watchdog_rst_i | bad_opcode_rst_i
                  | bad_fetch_rst_i | monitor_entry_rst_i | brownout_rst_i;
        access = psel_i & penable_i & ~cur.pready;
        // Master samples pready one edge after the access is taken
        commit = psel_i & penable_i & cur.pready & pwrite_i;
        next_cur.pready  = access;
        next_cur.pslverr = 1'b0;
        next_cur.pending = pending_source_flags_i;

        // Clear-on-read lands one cycle after data is returned
        if (cur.cause_clear) begin
            next_cur.cause = 8'h00;
        end
        next_cur.cause_clear = 1'b0;

        if (access) begin
            next_cur.prdata = UNMAPPED_DATA;
            if (addr_hit(paddr_i, PENDING_IRQ_STATUS_HI_ADDR)) begin
                next_cur.prdata = {24'h00_0000, cur.pending};
            end else if (addr_hit(paddr_i, RESET_CAUSE_STATUS_ADDR)) begin
                next_cur.prdata = {24'h00_0000, cur.cause};
                next_cur.cause_clear = ~pwrite_i;
            end else if (addr_hit(paddr_i, BREAK_FLAG_CONTROL_ADDR)) begin
                next_cur.prdata = {24'h00_0000, cur.bfc};
            end else if (addr_hit(paddr_i, LOWPOWER_STATUS_ADDR)) begin
                next_cur.prdata = {28'h000_0000, cur.break_wait,
                                   cur.pstate == RECOVER, cur.pstate == STOPPED,
                                   cur.pstate == WAITING};
            end else if (addr_hit(paddr_i, LOWPOWER_CONFIG_ADDR)) begin
                next_cur.prdata = {24'h00_0000, cur.config_bits};
            end else begin
                next_cur.pslverr = 1'b1;
            end
        end

        // Writes land on the edge where the master sees pready, not one earlier
        if (commit) begin
            if (addr_hit(paddr_i, BREAK_FLAG_CONTROL_ADDR)) begin
                next_cur.bfc = {pwdata_i[BREAK_CLEAR_ENABLE_BIT], 7'h00};
            end
            // Software write of one clears the break wait flag; a new break wins
            if (addr_hit(paddr_i, LOWPOWER_STATUS_ADDR) && pwdata_i[BREAK_WAIT_BIT]) begin
                next_cur.break_wait = 1'b0;
            end
            if (addr_hit(paddr_i, LOWPOWER_CONFIG_ADDR)) begin
                next_cur.config_bits = {5'h00, pwdata_i[2:0]};
            end
        end

        // Cause flags accumulate until read or power-up; power-up clears earlier flags; a new cause beats a pending clear
        if (power_up_i) begin
            next_cur.cause = 8'h00;
            next_cur.cause[POWER_UP_BIT] = 1'b1;
        end
        if (ext_pin_rst_i) begin
            next_cur.cause[EXT_PIN_BIT] = 1'b1;
        end
        if (watchdog_rst_i) begin
            next_cur.cause[WATCHDOG_BIT] = 1'b1;
        end
        if (bad_opcode_rst_i) begin
            next_cur.cause[BAD_OPCODE_BIT] = 1'b1;
        end
        if (bad_fetch_rst_i) begin
            next_cur.cause[BAD_FETCH_BIT] = 1'b1;
        end
        if (monitor_entry_rst_i) begin
            next_cur.cause[MONITOR_BIT] = 1'b1;
        end
        if (brownout_rst_i) begin
            next_cur.cause[BROWNOUT_BIT] = 1'b1;
        end
        next_cur.sysrst = any_reset;

        // Break protection: flags held while in break unless clear enabled
        next_cur.clr_allow = flag_clear_req_i
                           & (~break_state_i | cur.bfc[BREAK_CLEAR_ENABLE_BIT]);
        next_cur.trap = break_req_i;

        next_cur.clr_mask = 1'b0;
        next_cur.stack    = 1'b0;
        case (cur.pstate)
            RUN: begin
                next_cur.core_en   = 1'b1;
                next_cur.periph_en = 1'b1;
                next_cur.dbl_en    = 1'b1;
                next_cur.quad_en   = 1'b1;
                if (stop_instr_i) begin
                    next_cur.pstate   = STOPPED;
                    next_cur.clr_mask = 1'b1;
                    next_cur.counter  = 13'h0000;
                    next_cur.core_en  = 1'b0;
                    next_cur.periph_en = 1'b0;
                    next_cur.quad_en  = 1'b0;
                    next_cur.dbl_en   = cur.config_bits[OSC_IN_STOP_BIT];
                end else if (wait_instr_i) begin
                    next_cur.pstate   = WAITING;
                    next_cur.clr_mask = 1'b1;
                    next_cur.core_en  = 1'b0;
                end
            end
            WAITING: begin
                if (break_req_i) begin
                    next_cur.break_wait = 1'b1;
                    next_cur.pstate = RUN;
                    next_cur.core_en = 1'b1;
                end else if (irq_enabled_i && |pending_source_flags_i) begin
                    // Stacking pulse follows one cycle later
                    next_cur.pstate = STACKING;
                end
            end
            STOPPED: begin
                next_cur.counter = 13'h0000;
                if (break_req_i || (irq_enabled_i && |pending_source_flags_i)) begin
                    next_cur.pstate = RECOVER;
                    next_cur.quad_en = 1'b1;
                    next_cur.dbl_en = 1'b1;
                    if (break_req_i) begin
                        next_cur.break_wait = 1'b1;
                    end
                end
            end
            RECOVER: begin
                if (quad_tick_i) begin
                    next_cur.counter = cur.counter + 13'h0001;
                end
                if (cur.counter >= (cur.config_bits[SHORT_RECOVERY_BIT]
                                    ? SHORT_CNT : LONG_CNT)) begin
                    next_cur.pstate = STACKING;
                    next_cur.periph_en = 1'b1;
                end
            end
            STACKING: begin
                next_cur.stack = 1'b1;
                next_cur.core_en = 1'b1;
                next_cur.pstate = RUN;
            end
            default: begin
                next_cur.pstate = RUN;
            end
        endcase
        // Reset exits either low-power mode at once
        if (any_reset) begin
            next_cur.pstate = RUN;
        end
        next_cur.wdog_run = ~cur.config_bits[WATCHDOG_DIS_BIT]
                          & (cur.pstate != STOPPED);
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur             <= '0;
            cur.pstate      <= RUN;
            cur.cause       <= CAUSE_RESET;
            cur.pending     <= PENDING_RESET;
            cur.bfc         <= BFC_RESET;
            cur.config_bits <= CONFIG_RESET;
            cur.core_en     <= 1'b1;
            cur.periph_en   <= 1'b1;
            cur.dbl_en      <= 1'b1;
            cur.quad_en     <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata_o            = cur.prdata;
    assign pready_o            = cur.pready;
    assign pslverr_o           = cur.pslverr;
    assign force_trap_vector_o = cur.trap;
    assign clear_irq_mask_o    = cur.clr_mask;
    assign core_clk_en_o       = cur.core_en;
    assign periph_clk_en_o     = cur.periph_en;
    assign clk_double_en_o     = cur.dbl_en;
    assign clk_quad_en_o       = cur.quad_en;
    assign watchdog_run_o      = cur.wdog_run;
    assign stack_start_o       = cur.stack;
    assign flag_clear_allow_o  = cur.clr_allow;
    assign sys_reset_o         = cur.sysrst;

endmodule

/* sim_reset_lowpower_ctrl_asserts.sv */
`timescale 1ns/100ps
module sim_reset_lowpower_ctrl_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic break_req_i,
    input wire logic force_trap_vector_o,
    input wire logic flag_clear_req_i,
    input wire logic break_state_i,
    input wire logic flag_clear_allow_o,
    input wire logic wait_instr_i,
    input wire logic stop_instr_i,
    input wire logic clear_irq_mask_o,
    input wire logic core_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic clk_quad_en_o,
    input wire logic ext_pin_rst_i,
    input wire logic sys_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_trap_follows: assert property (##1 force_trap_vector_o == $past(break_req_i))
        else $error("trap lag");
    a_clear_idle: assert property (!flag_clear_req_i |=> !flag_clear_allow_o)
        else $error("clear without request");
    a_clear_outside: assert property (flag_clear_req_i && !break_state_i |=> flag_clear_allow_o)
        else $error("clear blocked");
    a_mask_entry: assert property ((wait_instr_i || stop_instr_i) && core_clk_en_o |=> clear_irq_mask_o)
        else $error("mask not cleared");
    a_wait_clocks: assert property (wait_instr_i && !stop_instr_i && core_clk_en_o |=> !core_clk_en_o && periph_clk_en_o)
        else $error("wait clocks");
    a_stop_gates: assert property (stop_instr_i && core_clk_en_o |=> !clk_quad_en_o && !periph_clk_en_o)
        else $error("stop clocks");
    a_reset_out: assert property (ext_pin_rst_i |=> sys_reset_o)
        else $error("reset missed");
    a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
        else $error("apb answer");
    c_wait: cover property (wait_instr_i && core_clk_en_o);
    c_stop: cover property (stop_instr_i && core_clk_en_o);
    c_break: cover property (flag_clear_req_i && break_state_i);
endmodule
bind sim_reset_lowpower_ctrl sim_reset_lowpower_ctrl_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .break_req_i(break_req_i),
    .force_trap_vector_o(force_trap_vector_o), .flag_clear_req_i(flag_clear_req_i),
    .break_state_i(break_state_i), .flag_clear_allow_o(flag_clear_allow_o),
    .wait_instr_i(wait_instr_i), .stop_instr_i(stop_instr_i), .clear_irq_mask_o(clear_irq_mask_o),
    .core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .clk_quad_en_o(clk_quad_en_o), .ext_pin_rst_i(ext_pin_rst_i), .sys_reset_o(sys_reset_o));

/* sim_reset_lowpower_ctrl_bench.sv */
`timescale 1ns/100ps
module sim_reset_lowpower_ctrl_bench;
    import sim_ctrl_pkg::*;
    localparam int LONG  = 40;
    localparam int SHORT = 4;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  p;
        logic [7:0]  e;
        logic        x;
    } row_t;
    row_t        rows [5] = '{'{12'h000, 8'h00, 8'h01, 8'h01, 1'b0}, '{12'h000, 8'hFF, 8'h5A, 8'h5A, 1'b0},
        '{12'h008, 8'h80, 8'h00, 8'h80, 1'b0}, '{12'h008, 8'h00, 8'h00, 8'h00, 1'b0},
        '{12'h100, 8'h00, 8'h00, 8'h00, 1'b1}};
    logic        clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic [7:0]  pend = 8'h00;
    logic [6:0]  cause = 7'h00;
    logic        irq_en = 1'b0, brk = 1'b0, brk_st = 1'b0, wt = 1'b0, stp = 1'b0, clr = 1'b0;
    logic        pready_o, pslverr_o, er, tick_q, trap, mask, core_en, per_en, dbl_en, quad_en;
    logic        wdog, stack, allow, sreset;
    int          err_count = 0, cmp_count = 0, n, k;
    always #5 clk_i = ~clk_i;
    periph_clock_model i_osc (.clk_i(clk_i), .rst_i(rst_i), .quad_tick_o(tick_q));
    sim_reset_lowpower_ctrl #(.LONG_RECOVERY(LONG), .SHORT_RECOVERY(SHORT)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pending_source_flags_i(pend),
        .irq_enabled_i(irq_en), .power_up_i(cause[6]), .ext_pin_rst_i(cause[5]),
        .watchdog_rst_i(cause[4]), .bad_opcode_rst_i(cause[3]), .bad_fetch_rst_i(cause[2]),
        .monitor_entry_rst_i(cause[1]), .brownout_rst_i(cause[0]), .break_req_i(brk),
        .break_state_i(brk_st), .wait_instr_i(wt), .stop_instr_i(stp), .quad_tick_i(tick_q),
        .flag_clear_req_i(clr), .force_trap_vector_o(trap), .clear_irq_mask_o(mask),
        .core_clk_en_o(core_en), .periph_clk_en_o(per_en), .clk_double_en_o(dbl_en),
        .clk_quad_en_o(quad_en), .watchdog_run_o(wdog), .stack_start_o(stack),
        .flag_clear_allow_o(allow), .sys_reset_o(sreset));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Starts on a fresh edge so a release and the next setup never share a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
        if (n >= 20) begin
            err_count++;
            $display("Error at %0t: no pready", $time);
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic w(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic final_report;
        $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        w(20);
        rst_i <= 1'b0;
        rdc(RESET_CAUSE_STATUS_ADDR, 32'h0000_0080);
        rdc(RESET_CAUSE_STATUS_ADDR, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            pend <= rows[i].p;
            apb(1'b1, rows[i].a, {24'h00_0000, rows[i].d});
            rdc(rows[i].a, {24'h00_0000, rows[i].e});
            chk({31'h0, er}, {31'h0, rows[i].x});
        end
        for (int i = 0; i < 8; i++) begin
            cause <= (i == 7) ? 7'h30 : 7'h01 << i;
            w(1);
            cause <= 7'h00;
            rdc(RESET_CAUSE_STATUS_ADDR, {24'h00_0000, (i == 7) ? 8'h60 : 8'h02 << i});
        end
        cause <= 7'h20;
        w(1);
        cause <= 7'h40;
        w(1);
        cause <= 7'h00;
        rdc(RESET_CAUSE_STATUS_ADDR, 32'h0000_0080);
        brk_st <= 1'b1;
        clr <= 1'b1;
        w(3);
        chk({31'h0, allow}, 32'h0);
        apb(1'b1, BREAK_FLAG_CONTROL_ADDR, 32'h0000_0080);
        w(3);
        chk({31'h0, allow}, 32'h1);
        apb(1'b1, BREAK_FLAG_CONTROL_ADDR, 32'h0000_0000);
        brk_st <= 1'b0;
        w(3);
        chk({31'h0, allow}, 32'h1);
        clr <= 1'b0;
        irq_en <= 1'b1;
        wt <= 1'b1;
        w(1);
        wt <= 1'b0;
        w(2);
        chk({29'h0, core_en, per_en, wdog}, 32'h3);
        pend <= 8'h01;
        k = 0;
        do begin w(1); k++; end while (stack !== 1'b1 && k < 9);
        chk(k, 3);
        pend <= 8'h00;
        w(3);
        wt <= 1'b1;
        w(1);
        wt <= 1'b0;
        brk <= 1'b1;
        w(2);
        chk({31'h0, trap}, 32'h1);
        brk <= 1'b0;
        rdc(LOWPOWER_STATUS_ADDR, 32'h0000_0008);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, LOWPOWER_CONFIG_ADDR, j ? 32'h0000_0001 : 32'h0000_0002);
            stp <= 1'b1;
            w(1);
            stp <= 1'b0;
            w(60);
            chk({30'h0, dbl_en, quad_en}, j ? 32'h0 : 32'h2);
            pend <= 8'h80;
            k = 0;
            for (n = 0; n < 500 && stack !== 1'b1; n++) begin w(1); k += int'(tick_q); end
            chk(32'(k >= (j ? SHORT : LONG) - 1 && k <= (j ? SHORT : LONG) + 2), 1);
            pend <= 8'h00;
            w(3);
        end
        apb(1'b1, LOWPOWER_CONFIG_ADDR, 32'h0000_0004);
        w(2);
        chk({31'h0, wdog}, 32'h0);
        rst_i <= 1'b1;
        w(2);
        rst_i <= 1'b0;
        rdc(RESET_CAUSE_STATUS_ADDR, 32'h0000_0080);
        final_report();
    end
endmodule
